//--- pkg/netstat_params.svh
// Purpose: Constants for the network status map register bank
// Assumes: Avalon-MM word addressing, 32-bit data, 16-bit registers
// Notes: Registers sit in the low half of each word
`ifndef NETSTAT_PARAMS_SVH
`define NETSTAT_PARAMS_SVH

// Word addresses (index); byte address is four times the index
`define ADR_HEALTHY_0 8'h00
`define ADR_HEALTHY_3 8'h03
`define ADR_CMD_BASE 8'h10
`define ADR_STS_BASE 8'h11
`define ADR_CH_LAST 8'h1d
`define ADR_ERRMAP_0 8'h20
`define ADR_ERRMAP_15 8'h2f
`define ADR_STATION 8'h30
`define ADR_ONLINE_0 8'h38
`define ADR_ONLINE_RSV_LAST 8'h3f
`define ADR_STANDBY_0 8'h40
`define ADR_STANDBY_RSV_LAST 8'h47
`define ADR_IRQ_STATUS 8'h50
`define ADR_IRQ_MASK 8'h51

// Station status word bit positions
`define STN_TEST 0
`define STN_MASTER 4
`define STN_SCAN_INH 5
`define STN_TERMINATE 6
`define STN_REPEAT 7
`define STN_L2_TX_INH 8
`define STN_L2_RX_INH 9
`define STN_L1_TX_INH 10
`define STN_L1_RX_INH 11
`define STN_ONLINE 12
`define STN_STANDBY 13
`define STN_OFFLINE 14
`define STN_DOWN 15
`define STN_USED_MASK 16'hfff1

// Interrupt status bits
`define IRQ_HEALTH_LOST 0
`define IRQ_UPDATE_ERR 1
`define IRQ_STATION_CHG 2
`define IRQ_MAP_CHG 3
`define IRQ_WIDTH 4

`define CMD_RESET 16'h0000
`endif

//--- pkg/netstat_pkg.sv
// Purpose: Types for the network status map register bank
// Assumes: Used as netstat_pkg::name, never imported
// Notes: Constants live in netstat_params.svh
package netstat_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} bus_state_e;
endpackage

//--- src/network_status_map.sv
// Purpose: Status register bank reporting plant network health
// Assumes: Adapters drive status levels synchronous to CLK_I
// Notes: One wait state per access; unmapped reads return zero
`timescale 1ns/1ns
`include "netstat_params.svh"

module network_status_map #(
  parameter int NUM_CH = 7,
  parameter int NUM_LINK = 256,
  parameter int NUM_STN = 64,
  parameter int NUM_HEALTHY = 64
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [NUM_HEALTHY-1:0] WORD_HEALTHY_I,
  input wire logic [NUM_LINK-1:0] LINK_UPDATE_FAIL_I,
  input wire logic [NUM_CH*16-1:0] CH_STATUS_I,
  output logic [NUM_CH*16-1:0] CH_COMMAND_O,
  input wire logic [15:0] STATION_STATUS_I,
  input wire logic [NUM_STN-1:0] STN_ONLINE_I,
  input wire logic [NUM_STN-1:0] STN_STANDBY_I,
  output logic IRQ_O
);

  localparam int HW = NUM_HEALTHY / 16;
  localparam int EW = NUM_LINK / 16;
  localparam int SW = NUM_STN / 16;

  netstat_pkg::bus_state_e bus_state_r;
  logic [NUM_HEALTHY-1:0] healthy_r;
  logic [NUM_LINK-1:0] errmap_r;
  logic [NUM_CH*16-1:0] ch_status_r;
  logic [NUM_CH*16-1:0] ch_cmd_r;
  logic [15:0] station_r;
  logic [NUM_STN-1:0] online_r;
  logic [NUM_STN-1:0] standby_r;
  logic [`IRQ_WIDTH-1:0] irq_sts_r;
  logic [`IRQ_WIDTH-1:0] irq_mask_r;
  logic [`IRQ_WIDTH-1:0] irq_evt;
  logic [15:0] rd_word;
  logic [7:0] ch_off;
  logic [7:0] adr;
  logic wr_take;
  logic [15:0] be_mask;

  assign adr = AVS_ADDRESS_I;
  assign wr_take = (bus_state_r == netstat_pkg::BUS_ANSWER) && AVS_WRITE_I;
  assign be_mask = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  assign ch_off = adr - `ADR_CMD_BASE;

  // Sample adapter levels; a registered copy keeps reads stable
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      healthy_r <= '0;
      errmap_r <= '0;
      ch_status_r <= '0;
      station_r <= '0;
      online_r <= '0;
      standby_r <= '0;
    end
    else
    begin
      healthy_r <= WORD_HEALTHY_I;
      errmap_r <= LINK_UPDATE_FAIL_I;
      ch_status_r <= CH_STATUS_I;
      // Unused station bits forced low so they read zero
      station_r <= STATION_STATUS_I & `STN_USED_MASK;
      online_r <= STN_ONLINE_I;
      standby_r <= STN_STANDBY_I;
    end
  end

  // Events: a flag dropping or rising, per the adapters' view
  always_comb
  begin
    irq_evt = '0;
    irq_evt[`IRQ_HEALTH_LOST] = |(healthy_r & ~WORD_HEALTHY_I);
    irq_evt[`IRQ_UPDATE_ERR] = |(~errmap_r & LINK_UPDATE_FAIL_I);
    irq_evt[`IRQ_STATION_CHG] =
      (station_r != (STATION_STATUS_I & `STN_USED_MASK));
    irq_evt[`IRQ_MAP_CHG] =
      (online_r != STN_ONLINE_I) || (standby_r != STN_STANDBY_I);
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      irq_sts_r <= '0;
    else if (wr_take && adr == `ADR_IRQ_STATUS && AVS_BYTEENABLE_I[0])
      irq_sts_r <= (irq_sts_r & ~AVS_WRITEDATA_I[`IRQ_WIDTH-1:0]) | irq_evt;
    else
      irq_sts_r <= irq_sts_r | irq_evt;
  end

  // Mask register gates status onto the interrupt line
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      irq_mask_r <= '0;
    else if (wr_take && adr == `ADR_IRQ_MASK && AVS_BYTEENABLE_I[0])
      irq_mask_r <= AVS_WRITEDATA_I[`IRQ_WIDTH-1:0];
  end

  // Interrupt level registered so the output comes from a flip-flop
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(irq_sts_r & irq_mask_r);
  end

  // Channel command words, one per channel, byte-lane writes
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++)
    begin : g_cmd
      always_ff @(posedge CLK_I or negedge RST_N_I)
      begin
        if (!RST_N_I)
          ch_cmd_r[gc*16 +: 16] <= `CMD_RESET;
        else if (wr_take && adr >= `ADR_CMD_BASE && adr <= `ADR_CH_LAST
                 && ch_off[0] == 1'b0 && ch_off[7:1] == 7'(gc))
          ch_cmd_r[gc*16 +: 16] <= (ch_cmd_r[gc*16 +: 16] & ~be_mask)
                                   | (AVS_WRITEDATA_I[15:0] & be_mask);
      end
    end
  endgenerate

  assign CH_COMMAND_O = ch_cmd_r;

  // Read decode; all maps pack sixteen per word, low index at bit 0
  always_comb
  begin
    rd_word = 16'h0000;
    if (adr >= `ADR_HEALTHY_0 && adr < `ADR_HEALTHY_0 + 8'(HW))
      rd_word = healthy_r[(adr - `ADR_HEALTHY_0)*16 +: 16];
    else if (adr >= `ADR_CMD_BASE && adr <= `ADR_CH_LAST)
    begin
      if (ch_off[0] == 1'b0)
        rd_word = ch_cmd_r[ch_off[7:1]*16 +: 16];
      else
        rd_word = ch_status_r[ch_off[7:1]*16 +: 16];
    end
    else if (adr >= `ADR_ERRMAP_0 && adr < `ADR_ERRMAP_0 + 8'(EW))
      rd_word = errmap_r[(adr - `ADR_ERRMAP_0)*16 +: 16];
    else if (adr == `ADR_STATION)
      rd_word = station_r;
    else if (adr >= `ADR_ONLINE_0 && adr < `ADR_ONLINE_0 + 8'(SW))
      rd_word = online_r[(adr - `ADR_ONLINE_0)*16 +: 16];
    else if (adr >= `ADR_STANDBY_0 && adr < `ADR_STANDBY_0 + 8'(SW))
      rd_word = standby_r[(adr - `ADR_STANDBY_0)*16 +: 16];
    else if (adr == `ADR_IRQ_STATUS)
      rd_word = {12'h000, irq_sts_r};
    else if (adr == `ADR_IRQ_MASK)
      rd_word = {12'h000, irq_mask_r};
    else
      rd_word = 16'h0000; // Reserved words read zero
  end

  // Avalon slave: one wait cycle, then answer; writes to RO ignored
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      bus_state_r <= netstat_pkg::BUS_IDLE;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end
    else
    begin
      case (bus_state_r)
        netstat_pkg::BUS_IDLE:
        begin
          if (AVS_READ_I || AVS_WRITE_I)
          begin
            bus_state_r <= netstat_pkg::BUS_ANSWER;
            AVS_WAITREQUEST_O <= 1'b0;
            AVS_READDATA_O <= {16'h0000, rd_word};
          end
        end
        default:
        begin
          bus_state_r <= netstat_pkg::BUS_IDLE;
          AVS_WAITREQUEST_O <= 1'b1;
        end
      endcase
    end
  end

endmodule

//--- dv/network_status_map_sva.sv
// Purpose: Bus timing and readback checks for the status bank
// Assumes: Status inputs stay steady around each read
// Notes: Reads show inputs two edges before the answer
`timescale 1ns/1ns
`include "netstat_params.svh"
module network_status_map_sva #(
  parameter int NUM_STN = 64
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [15:0] STATION_STATUS_I,
  input wire logic [NUM_STN-1:0] STN_ONLINE_I,
  input wire logic [NUM_STN-1:0] STN_STANDBY_I,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Any request, and a read that the bank takes this cycle
  wire logic req = AVS_READ_I || AVS_WRITE_I;
  wire logic rd = AVS_READ_I && AVS_WAITREQUEST_O;
  // Exactly one answer cycle, never one unasked
  chk_wait_answer: assert property (req && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O) else $error("no answer");
  chk_wait_single: assert property (!AVS_WAITREQUEST_O
    |=> AVS_WAITREQUEST_O) else $error("answer too long");
  chk_wait_idle: assert property (!req && AVS_WAITREQUEST_O
    |=> AVS_WAITREQUEST_O) else $error("answer unasked");
  chk_upper_zero: assert property (!AVS_WAITREQUEST_O
    |-> AVS_READDATA_O[31:16] == 16'h0000) else $error("upper set");
  // Readback of the loop network words
  chk_station_read: assert property (
    rd && AVS_ADDRESS_I == 8'h30 |=>
    AVS_READDATA_O == {16'h0000, $past(STATION_STATUS_I, 2)
    & `STN_USED_MASK}) else $error("station word");
  chk_online_read: assert property (
    rd && AVS_ADDRESS_I == 8'h38 |=>
    AVS_READDATA_O == {16'h0000, $past(STN_ONLINE_I[15:0], 2)})
    else $error("online map");
  chk_standby_read: assert property (
    rd && AVS_ADDRESS_I == 8'h43 |=>
    AVS_READDATA_O[15:0] == $past(STN_STANDBY_I[NUM_STN-1-:16], 2))
    else $error("standby map");
  chk_reserved_zero: assert property (
    rd && AVS_ADDRESS_I inside
    {[8'h3c:8'h3f], [8'h44:8'h47]} |=> AVS_READDATA_O == 32'h0)
    else $error("reserved word");
  cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
  cover property (rd && AVS_ADDRESS_I == 8'h30);
  cover property ($rose(IRQ_O));
endmodule
bind network_status_map network_status_map_sva #(.NUM_STN(NUM_STN)) sva (
  .CLK_I, .RST_N_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_READDATA_O, .AVS_WAITREQUEST_O, .STATION_STATUS_I,
  .STN_ONLINE_I, .STN_STANDBY_I, .IRQ_O);

//--- dv/netstat_adapter.sv
// Purpose: Network adapters that feed every status input
// Assumes: A new picture only when stepped
// Notes: Mode 1 all ones, 2 all zeros, else random
`timescale 1ns/1ns
module netstat_adapter (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic [1:0] mode_i,
  output logic [575:0] pool_o
);
  int seed = 73182;
  initial pool_o = '0;
  // Whole picture changes at once, like a fresh scan
  always @(posedge clk_i)
    if (step_i)
      for (int i = 0; i < 18; i++)
        pool_o[i*32+:32] <= mode_i == 2'h1 ? 32'hffffffff :
          mode_i == 2'h2 ? 32'h00000000 : $random(seed);
endmodule

//--- dv/network_status_map_test.sv
// Purpose: Self-checking run of the status bank
// Assumes: Adapter model drives every status input
// Notes: Each round steps the adapters, checks events, sweeps map
`timescale 1ns/1ns
module network_status_map_test;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, step = 0, wq, irq, i0, i1;
  logic [1:0] mode = 0;
  logic [7:0] adr = 0;
  logic [15:0] d;
  logic [31:0] wd = 0, rdata, q;
  logic [575:0] p, o;
  logic [111:0] cc;
  int errors = 0, samples_checked = 0, cyc = 0;
  always #5 clk = ~clk;
  netstat_adapter nets (.clk_i(clk), .step_i(step), .mode_i(mode),
    .pool_o(p));
  network_status_map uut (.CLK_I(clk), .RST_N_I(rst_n),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wq),
    .WORD_HEALTHY_I(p[63:0]), .LINK_UPDATE_FAIL_I(p[319:64]),
    .CH_STATUS_I(p[431:320]), .CH_COMMAND_O(cc),
    .STATION_STATUS_I(p[447:432]), .STN_ONLINE_I(p[511:448]),
    .STN_STANDBY_I(p[575:512]), .IRQ_O(irq));
  // Expected word at a map index
  function logic [15:0] want(input int a);
    if (a < 4) return p[a*16+:16];
    if (a >= 32 && a < 48) return p[64+(a-32)*16+:16];
    if (a == 48) return p[447:432] & 16'hfff1;
    if (a >= 56 && a < 60) return p[448+(a-56)*16+:16];
    if (a >= 64 && a < 68) return p[512+(a-64)*16+:16];
    if (a >= 17 && a < 30 && a % 2 == 1) return p[320+(a-17)*8+:16];
    return 16'h0000;
  endfunction
  // Events since the last picture
  function logic [31:0] want_irq();
    return {28'h0, o[575:448] != p[575:448],
      (o[447:432] & 16'hfff1) != (p[447:432] & 16'hfff1),
      |(~o[319:64] & p[319:64]), |(o[63:0] & ~p[63:0])};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Held until waitrequest is seen low, then released
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [15:0] v, output logic [31:0] r);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {16'h0000, v};
    @(posedge clk);
    while (wq !== 1'b0)
      @(posedge clk);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Irq is registered, so sample it well clear of the edge
  task irq_at(input logic [15:0] m, output logic v);
    bus(1, 8'h51, m, q);
    repeat (3) @(negedge clk);
    v = irq;
    @(posedge clk);
  endtask
  task complete_run();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
    if (++cyc == 5000)
    begin
      errors++;
      complete_run();
    end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int r = 0; r < 4; r++)
    begin
      bus(1, 8'h50, 16'h000f, q);
      o = p;
      mode <= r < 2 ? r + 1 : 0;
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      repeat (3) @(posedge clk);
      bus(0, 8'h50, 0, q);
      chk(q, want_irq());
      irq_at(16'h0000, i0);
      irq_at(16'h000f, i1);
      chk(i0 ^ i1, {31'h0, want_irq() != 0});
      bus(0, 8'h51, 0, q);
      chk(q, 32'h0000000f);
      bus(1, 8'h50, 16'h000f, q);
      irq_at(16'h000f, i0);
      chk(i0, 0);
      // Write every word from 0x00 to 0x4f, then read it back
      for (int a = 0; a < 80; a++)
      begin
        d = $random(nets.seed);
        bus(1, a[7:0], d, q);
        bus(0, a[7:0], 0, q);
        if (a >= 16 && a < 30 && a % 2 == 0)
        begin
          chk(q, {16'h0000, d});
          chk(cc[(a-16)*8+:16], d);
        end
        else
          chk(q, want(a));
      end
    end
    complete_run();
  end
endmodule
